// ---- apoc_pkg.sv ----
package apoc_pkg;
  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int BIT_RW = 15;
  localparam int BIT_BANK = 14;
  // ---------------------------------------------------------------
  // master page register offsets (12-bit address)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_PAGE_SELECT = 12'h011;
  localparam logic [11:0] OFS_MASK1_CONV = 12'h020;
  localparam logic [11:0] OFS_MASK1_BUF = 12'h021;
  localparam logic [11:0] OFS_MASK2_CONV = 12'h023;
  localparam logic [11:0] OFS_MASK2_BUF = 12'h024;
  localparam logic [11:0] OFS_PD_CONFIG = 12'h026;
  localparam logic [11:0] OFS_SYNC_PULSE = 12'h053;
  localparam logic [11:0] OFS_SYNC_ENABLE = 12'h054;
  localparam logic [11:0] OFS_MASK_ENABLE = 12'h055;
  localparam logic [11:0] OFS_TRIP_LEVEL = 12'h05F;
  localparam logic [11:0] OFS_FLAG_ROUTE = 12'h060;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PAGE_MASTER = 8'h80;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_TRIP_LEVEL = 8'hE3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MASK_BUF_BITS = 8'hF0;
  localparam logic [7:0] MASK_CFG_BITS = 8'hE0;
  localparam logic [7:0] MASK_SYNC_BITS = 8'h41;
  localparam logic [7:0] MASK_MEN_BITS = 8'h10;
  localparam logic [7:0] MASK_ROUTE_BITS = 8'h07;
  localparam int CFG_GLOBAL = 7;
  localparam int CFG_OVERRIDE = 6;
  localparam int CFG_MASK_SEL = 5;
  localparam int MEN_BIT = 4;
  localparam int SYNC_MANUAL_BIT = 7;
  localparam int SYNC_LEVEL_BIT = 0;
  localparam int SYNC_BLOCK_BIT = 6;
  localparam int ROUTE_STREAM = 0;
  localparam int ROUTE_READBACK = 1;
  localparam int ROUTE_PDPIN = 2;
  localparam int FULL_SCALE_DIV = 255;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int OVR_LATENCY_CYC = 18;
  localparam int SMPL_W = 16;
endpackage

// ---- apoc_delay.sv ----
`timescale 1ns/1ns
module apoc_delay #(
  parameter int DEPTH = 18
) (
  input wire logic clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire logic en, // one-cycle advance enable
  input wire logic din, // level in
  output logic dout // level after DEPTH enables
);
  logic [DEPTH-1:0] pipe_r;

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pipe_r[i] <= 1'b0;
        end else if (en) begin
          pipe_r[i] <= (i == 0) ? din : pipe_r[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign dout = pipe_r[DEPTH-1];
endmodule

// ---- apoc_ctrl.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - one sync pulse resets internal counters
// - overrange flag in stream or pins
// - flag replaces sample word LSB
// - flag appears 18 sample clocks later
// - trip level is full scale times field/255
// - trip field resets to E3h
// - sleep by pin or register bits
// - two masks, converter and buffer fields
// - config: global, pin override, mask choice
// - global sleep powers down everything
// - mask bits act only when enabled
// - frames are 16 address, 8 data
// - shift on select low, rising edges
// - four control bits then 12-bit address
// - read drives register onto readback pin unless flag is routed there
module apoc_ctrl
  import apoc_pkg::*;
#(
  parameter int SMPL_WIDTH = apoc_pkg::SMPL_W
) (
  input wire logic clk, // block clock, 20 MHz
  input wire logic resetn, // async reset, active low
  input wire logic serial_clk, // host serial clock pin
  input wire logic serial_select_n, // frame select, active low
  input wire logic serial_input_line, // host data pin
  output logic serial_readback_out, // readback data pin
  output logic serial_readback_oe_n, // readback drive enable, low drives
  input wire logic power_down_pin_in, // power down pin level
  output logic power_down_pin_out, // flag driven on power down pin
  output logic power_down_pin_oe_n, // power down pin drive, low drives
  input wire logic sample_strobe, // one-cycle sample clock enable
  input wire logic [SMPL_WIDTH-1:0] sample_a, // channel A sample, two's complement
  input wire logic [SMPL_WIDTH-1:0] sample_b, // channel B sample
  output logic [SMPL_WIDTH-1:0] enc_word_a, // word to encoder, channel A
  output logic [SMPL_WIDTH-1:0] enc_word_b, // word to encoder, channel B
  output logic fast_overrange_flag, // delayed overrange level
  output logic whole_chip_sleep, // full power down incl. link
  output logic conv_a_sleep, // converter A power down
  output logic conv_b_sleep, // converter B power down
  output logic buf_a_sleep, // input buffer A power down
  output logic buf_b_sleep, // input buffer B power down
  output logic sync_ref_pulse // software sync reference level
);
  import apoc_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sclk_s_r, sel_s_r, din_s_r, pdp_s_r;
  logic sclk_d_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s_r <= 2'h0;
      sel_s_r <= 2'h3;
      din_s_r <= 2'h0;
      pdp_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], serial_clk};
      sel_s_r <= {sel_s_r[0], serial_select_n};
      din_s_r <= {din_s_r[0], serial_input_line};
      pdp_s_r <= {pdp_s_r[0], power_down_pin_in};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s_r[1];
    end
  end

  logic sel_act, sclk_rise, sclk_fall;
  assign sel_act = ~sel_s_r[1];
  assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  assign sclk_fall = ~sclk_s_r[1] & sclk_d_r;

  // ---------------------------------------------------------------
  // frame shifter
  // ---------------------------------------------------------------
  logic [FRAME_BITS-2:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic frame_done;

  assign frame_done = sel_act && sclk_rise && (bit_cnt_r == 5'(FRAME_BITS - 1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= 5'h00;
      shift_r <= '0;
    end else if (!sel_act) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      shift_r <= {shift_r[FRAME_BITS-3:0], din_s_r[1]};
      bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  logic [7:0] page_r;
  logic [15:0] addr_w, hdr_w;
  logic [7:0] wdata_w;
  logic is_read_hdr, master_hit, hdr_hit;
  assign addr_w = shift_r[FRAME_BITS-2:DATA_BITS-1];
  // mid-frame the header sits at the bottom of the shifter, not the top
  assign hdr_w = shift_r[ADDR_BITS-1:0];
  assign wdata_w = {shift_r[DATA_BITS-2:0], din_s_r[1]};
  assign is_read_hdr = hdr_w[BIT_RW];
  assign master_hit = ~addr_w[BIT_BANK] && (page_r == PAGE_MASTER || addr_w[11:0] == OFS_PAGE_SELECT);
  assign hdr_hit = ~hdr_w[BIT_BANK] && (page_r == PAGE_MASTER || hdr_w[11:0] == OFS_PAGE_SELECT);

  logic wr_stb;
  assign wr_stb = frame_done && ~addr_w[BIT_RW] && master_hit;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] m1c_r, m1b_r, m2c_r, m2b_r, cfg_r;
  logic [7:0] spulse_r, sen_r, men_r, trip_r, route_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_r <= RST_PAGE;
    end else if (wr_stb && addr_w[11:0] == OFS_PAGE_SELECT) begin
      page_r <= wdata_w;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m1c_r <= RST_ZERO;
      m1b_r <= RST_ZERO;
      m2c_r <= RST_ZERO;
      m2b_r <= RST_ZERO;
    end else if (wr_stb) begin
      if (addr_w[11:0] == OFS_MASK1_CONV) begin
        m1c_r <= wdata_w;
      end else if (addr_w[11:0] == OFS_MASK1_BUF) begin
        m1b_r <= wdata_w & MASK_BUF_BITS;
      end else if (addr_w[11:0] == OFS_MASK2_CONV) begin
        m2c_r <= wdata_w;
      end else if (addr_w[11:0] == OFS_MASK2_BUF) begin
        m2b_r <= wdata_w & MASK_BUF_BITS;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= RST_ZERO;
      men_r <= RST_ZERO;
    end else if (wr_stb) begin
      if (addr_w[11:0] == OFS_PD_CONFIG) begin
        cfg_r <= wdata_w & MASK_CFG_BITS;
      end else if (addr_w[11:0] == OFS_MASK_ENABLE) begin
        men_r <= wdata_w & MASK_MEN_BITS;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spulse_r <= RST_ZERO;
      sen_r <= RST_ZERO;
    end else if (wr_stb) begin
      if (addr_w[11:0] == OFS_SYNC_PULSE) begin
        spulse_r <= wdata_w & MASK_SYNC_BITS;
      end else if (addr_w[11:0] == OFS_SYNC_ENABLE) begin
        sen_r <= wdata_w;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trip_r <= RST_TRIP_LEVEL;
      route_r <= RST_ZERO;
    end else if (wr_stb) begin
      if (addr_w[11:0] == OFS_TRIP_LEVEL) begin
        trip_r <= wdata_w;
      end else if (addr_w[11:0] == OFS_FLAG_ROUTE) begin
        route_r <= wdata_w & MASK_ROUTE_BITS;
      end
    end
  end

  // ---------------------------------------------------------------
  // readback
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hdr_w[11:0] == OFS_PAGE_SELECT) begin
      rd_mux = page_r;
    end else if (hdr_w[11:0] == OFS_MASK1_CONV) begin
      rd_mux = m1c_r;
    end else if (hdr_w[11:0] == OFS_MASK1_BUF) begin
      rd_mux = m1b_r;
    end else if (hdr_w[11:0] == OFS_MASK2_CONV) begin
      rd_mux = m2c_r;
    end else if (hdr_w[11:0] == OFS_MASK2_BUF) begin
      rd_mux = m2b_r;
    end else if (hdr_w[11:0] == OFS_PD_CONFIG) begin
      rd_mux = cfg_r;
    end else if (hdr_w[11:0] == OFS_SYNC_PULSE) begin
      rd_mux = spulse_r;
    end else if (hdr_w[11:0] == OFS_SYNC_ENABLE) begin
      rd_mux = sen_r;
    end else if (hdr_w[11:0] == OFS_MASK_ENABLE) begin
      rd_mux = men_r;
    end else if (hdr_w[11:0] == OFS_TRIP_LEVEL) begin
      rd_mux = trip_r;
    end else if (hdr_w[11:0] == OFS_FLAG_ROUTE) begin
      rd_mux = route_r;
    end
  end

  logic [7:0] rd_sh_r;
  logic rd_act_r;
  logic hdr_done;
  // header complete once 16 bits are in; shift_r then holds the address
  assign hdr_done = sel_act && (bit_cnt_r == 5'(ADDR_BITS)) && ~rd_act_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_sh_r <= 8'h00;
      rd_act_r <= 1'b0;
    end else if (!sel_act || frame_done) begin
      rd_act_r <= 1'b0;
    end else if (hdr_done && is_read_hdr && hdr_hit) begin
      rd_act_r <= 1'b1;
      rd_sh_r <= rd_mux;
    end else if (rd_act_r && sclk_fall && bit_cnt_r > 5'(ADDR_BITS)) begin
      rd_sh_r <= {rd_sh_r[6:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // overrange detection, sample domain as enable
  // ---------------------------------------------------------------
  function automatic logic over_trip(input logic [SMPL_WIDTH-1:0] s, input logic [7:0] lvl);
    logic [SMPL_WIDTH-1:0] mag;
    logic [SMPL_WIDTH+8:0] lhs, rhs;
    mag = s[SMPL_WIDTH-1] ? SMPL_WIDTH'(~s) : s;
    lhs = (SMPL_WIDTH+9)'(mag) * (SMPL_WIDTH+9)'(FULL_SCALE_DIV);
    rhs = (SMPL_WIDTH+9)'(lvl) << (SMPL_WIDTH - 1);
    return lhs > rhs;
  endfunction

  logic raw_ovr;
  assign raw_ovr = over_trip(sample_a, trip_r) | over_trip(sample_b, trip_r);

  logic ovr_dly;
  apoc_delay #(
    .DEPTH(OVR_LATENCY_CYC)
  ) u_ovr_delay (
    .clk(clk),
    .resetn(resetn),
    .en(sample_strobe),
    .din(raw_ovr),
    .dout(ovr_dly)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fast_overrange_flag <= 1'b0;
    end else begin
      fast_overrange_flag <= ovr_dly;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enc_word_a <= '0;
      enc_word_b <= '0;
    end else if (sample_strobe) begin
      enc_word_a <= route_r[ROUTE_STREAM] ? {sample_a[SMPL_WIDTH-1:1], ovr_dly} : sample_a;
      enc_word_b <= route_r[ROUTE_STREAM] ? {sample_b[SMPL_WIDTH-1:1], ovr_dly} : sample_b;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_readback_out <= 1'b0;
      serial_readback_oe_n <= 1'b1;
      power_down_pin_out <= 1'b0;
      power_down_pin_oe_n <= 1'b1;
    end else begin
      serial_readback_out <= route_r[ROUTE_READBACK] ? ovr_dly : (rd_act_r & rd_sh_r[7]);
      serial_readback_oe_n <= ~(route_r[ROUTE_READBACK] | rd_act_r);
      power_down_pin_out <= ovr_dly;
      power_down_pin_oe_n <= ~route_r[ROUTE_PDPIN];
    end
  end

  // ---------------------------------------------------------------
  // power down
  // ---------------------------------------------------------------
  logic pin_sleep, mask_on, all_sleep;
  logic [7:0] conv_sel, buf_sel;
  assign pin_sleep = pdp_s_r[1] & ~cfg_r[CFG_OVERRIDE] & route_r[ROUTE_PDPIN] == 1'b0;
  assign mask_on = men_r[MEN_BIT];
  // pin sleep is a full power down like the global bit, but only while the mask enable bit is clear
  assign all_sleep = cfg_r[CFG_GLOBAL] | (pin_sleep & ~mask_on);
  assign conv_sel = cfg_r[CFG_MASK_SEL] ? m2c_r : m1c_r;
  assign buf_sel = cfg_r[CFG_MASK_SEL] ? m2b_r : m1b_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      whole_chip_sleep <= 1'b0;
      conv_a_sleep <= 1'b0;
      conv_b_sleep <= 1'b0;
      buf_a_sleep <= 1'b0;
      buf_b_sleep <= 1'b0;
    end else begin
      whole_chip_sleep <= all_sleep;
      conv_a_sleep <= all_sleep | (mask_on & |conv_sel[7:4]);
      conv_b_sleep <= all_sleep | (mask_on & |conv_sel[3:0]);
      buf_b_sleep <= all_sleep | (mask_on & |buf_sel[7:6]);
      buf_a_sleep <= all_sleep | (mask_on & |buf_sel[5:4]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_ref_pulse <= 1'b0;
    end else begin
      sync_ref_pulse <= sen_r[SYNC_MANUAL_BIT] & spulse_r[SYNC_LEVEL_BIT] & ~spulse_r[SYNC_BLOCK_BIT];
    end
  end
endmodule

// ---- apoc_chk.sv ----
`timescale 1ns/1ns
module apoc_chk #(
  parameter int SMPL_WIDTH = 16
) (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic serial_clk, // host clock
  input wire logic serial_select_n, // frame select
  input wire logic serial_readback_out, // readback
  input wire logic serial_readback_oe_n, // readback drive
  input wire logic power_down_pin_out, // pin out
  input wire logic power_down_pin_oe_n, // pin drive
  input wire logic sample_strobe, // sample enable
  input wire logic [SMPL_WIDTH-1:0] sample_a, // sample in
  input wire logic [SMPL_WIDTH-1:0] enc_word_a, // word out
  input wire logic fast_overrange_flag, // flag
  input wire logic whole_chip_sleep, // global sleep
  input wire logic conv_a_sleep, // sleep a
  input wire logic conv_b_sleep, // sleep b
  input wire logic buf_a_sleep, // buffer a
  input wire logic buf_b_sleep, // buffer b
  input wire logic sync_ref_pulse // sync level
);
  logic sclk_r;
  logic [7:0] rise_age_r;
  logic [7:0] fall_age_r;
  // ----
  // ages of raw serial clock edges
  // ----
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_r <= 1'b0;
      rise_age_r <= 8'hFF;
      fall_age_r <= 8'hFF;
    end else begin
      sclk_r <= serial_clk;
      rise_age_r <= (serial_clk && !sclk_r) ? 8'h00 : rise_age_r + {7'h00, rise_age_r != 8'hFF};
      fall_age_r <= (!serial_clk && sclk_r) ? 8'h00 : fall_age_r + {7'h00, fall_age_r != 8'hFF};
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  global_sleep_a:
  assert property (whole_chip_sleep |-> conv_a_sleep && conv_b_sleep && buf_a_sleep && buf_b_sleep)
    else $error("global sleep left a block awake");
  ovr_latency_a:
  assert property ($changed(fast_overrange_flag) |-> $past(sample_strobe, 2))
    else $error("flag moved off the strobe timing");
  stream_word_a:
  assert property (sample_strobe |=> enc_word_a[SMPL_WIDTH-1:1] == $past(sample_a[SMPL_WIDTH-1:1]))
    else $error("encoder word upper bits wrong");
  pd_pin_flag_a:
  assert property ((!power_down_pin_oe_n && $stable(fast_overrange_flag)) [*2] |->
    power_down_pin_out == fast_overrange_flag)
    else $error("pin does not carry the flag");
  readback_hold_a:
  assert property ($changed(serial_readback_out) && !serial_readback_oe_n && !serial_select_n &&
    $stable(fast_overrange_flag) |-> fall_age_r <= 8'd5 || rise_age_r <= 8'd5)
    else $error("readback changed away from a clock edge");
  sync_write_a:
  assert property ($changed(sync_ref_pulse) |-> rise_age_r <= 8'd10)
    else $error("sync level changed outside a write");
  reset_idle_a:
  assert property ($rose(resetn) |-> serial_readback_oe_n && power_down_pin_oe_n && !whole_chip_sleep)
    else $error("outputs not idle after reset");
  flag_level_a:
  assert property ($rose(fast_overrange_flag) |=> fast_overrange_flag)
    else $error("flag is not a level");
  ovr_seen_c: cover property ($rose(fast_overrange_flag));
  read_seen_c: cover property ($fell(serial_readback_oe_n));
  sync_seen_c: cover property ($rose(sync_ref_pulse));
  sleep_seen_c: cover property ($rose(whole_chip_sleep));
endmodule

bind apoc_ctrl apoc_chk #(.SMPL_WIDTH(SMPL_WIDTH)) i_apoc_chk (.clk(clk), .resetn(resetn),
  .serial_clk(serial_clk), .serial_select_n(serial_select_n), .serial_readback_out(serial_readback_out),
  .serial_readback_oe_n(serial_readback_oe_n), .power_down_pin_out(power_down_pin_out),
  .power_down_pin_oe_n(power_down_pin_oe_n), .sample_strobe(sample_strobe), .sample_a(sample_a),
  .enc_word_a(enc_word_a), .fast_overrange_flag(fast_overrange_flag), .whole_chip_sleep(whole_chip_sleep),
  .conv_a_sleep(conv_a_sleep), .conv_b_sleep(conv_b_sleep), .buf_a_sleep(buf_a_sleep),
  .buf_b_sleep(buf_b_sleep), .sync_ref_pulse(sync_ref_pulse));

// ---- apoc_host.sv ----
`timescale 1ns/1ns
module apoc_host (
  input wire logic clk, // block clock
  input wire logic serial_readback_out, // readback data
  input wire logic serial_readback_oe_n, // readback drive
  output logic serial_clk, // host clock
  output logic serial_select_n, // frame select
  output logic serial_input_line // host data
);
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_input_line = 1'b0;
  end
  // ----
  // frames
  // ----
  // 24 bits msb first
  task automatic xfer(input logic [23:0] f, output logic [7:0] rd, output logic drv);
    drv = 1'b1;
    rd = 8'h00;
    serial_select_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 23; i >= 0; i--) begin
      serial_input_line <= f[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      // mid high phase: the pin settles a few clocks after each edge
      repeat (2) @(posedge clk);
      if (i < 8) begin
        rd[i] = serial_readback_out;
        drv = drv & !serial_readback_oe_n;
      end
      repeat (2) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    serial_select_n <= 1'b1;
    // released line shows the inverse, never the last bit
    serial_input_line <= !f[0];
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic v;
    xfer({4'h0, a, d}, r, v);
  endtask
endmodule

// ---- apoc_ctrl_tb_top.sv ----
`timescale 1ns/1ns
module apoc_ctrl_tb_top;
  import apoc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pd_in = 1'b0;
  logic sample_strobe = 1'b0;
  logic [1:0] scnt = 2'h0;
  logic [15:0] sample_a = 16'h0000;
  logic [15:0] sample_b = 16'h0000;
  logic sclk, sel_n, sdi, rb, rb_oe_n, pd_out, pd_oe_n, flag, sync;
  logic whole, ca, cb, ba, bb;
  logic [15:0] enc_a, enc_b;
  wire [15:0] slp = {11'h000, whole, ca, cb, ba, bb};
  int bad_count = 0;
  int n_tests = 0;
  always #25 clk = !clk;
  always @(posedge clk) begin
    scnt <= scnt + 2'h1;
    sample_strobe <= (scnt == 2'h3);
  end
  apoc_ctrl i_apoc_ctrl (.clk(clk), .resetn(resetn), .serial_clk(sclk), .serial_select_n(sel_n),
    .serial_input_line(sdi), .serial_readback_out(rb), .serial_readback_oe_n(rb_oe_n),
    .power_down_pin_in(pd_in), .power_down_pin_out(pd_out), .power_down_pin_oe_n(pd_oe_n),
    .sample_strobe(sample_strobe), .sample_a(sample_a), .sample_b(sample_b), .enc_word_a(enc_a),
    .enc_word_b(enc_b), .fast_overrange_flag(flag), .whole_chip_sleep(whole), .conv_a_sleep(ca),
    .conv_b_sleep(cb), .buf_a_sleep(ba), .buf_b_sleep(bb), .sync_ref_pulse(sync));
  apoc_host i_apoc_host (.clk(clk), .serial_readback_out(rb), .serial_readback_oe_n(rb_oe_n),
    .serial_clk(sclk), .serial_select_n(sel_n), .serial_input_line(sdi));
  // ----
  // helpers
  // ----
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic v;
    i_apoc_host.xfer({4'h8, a, 8'h00}, r, v);
    chk("readback", {8'h01, e}, {7'h00, v, r});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    logic [7:0] r;
    logic v;
    chk("sleep", 16'h0000, slp);
    i_apoc_host.wr(OFS_PAGE_SELECT, PAGE_MASTER);
    rdchk(OFS_PAGE_SELECT, PAGE_MASTER);
    rdchk(OFS_TRIP_LEVEL, RST_TRIP_LEVEL);
    rdchk(12'h0FF, 8'h00);
    i_apoc_host.wr(OFS_MASK1_BUF, 8'hFF);
    rdchk(OFS_MASK1_BUF, MASK_BUF_BITS);
    i_apoc_host.wr(OFS_MASK2_BUF, 8'hFF);
    rdchk(OFS_MASK2_BUF, MASK_BUF_BITS);
    i_apoc_host.xfer({4'h4, OFS_MASK_ENABLE, 8'h10}, r, v);
    rdchk(OFS_MASK_ENABLE, 8'h00);
  endtask
  task automatic t_sleep;
    i_apoc_host.wr(OFS_MASK1_CONV, 8'hFF);
    i_apoc_host.wr(OFS_MASK2_BUF, 8'h00);
    chk("sleep", 16'h0000, slp);
    i_apoc_host.wr(OFS_MASK_ENABLE, 8'h10);
    chk("sleep", 16'h000F, slp);
    i_apoc_host.wr(OFS_PD_CONFIG, 8'h20);
    chk("sleep", 16'h0000, slp);
    i_apoc_host.wr(OFS_PD_CONFIG, 8'h80);
    chk("sleep", 16'h001F, slp);
    rdchk(OFS_PD_CONFIG, 8'h80);
    i_apoc_host.wr(OFS_PD_CONFIG, 8'h00);
    i_apoc_host.wr(OFS_MASK_ENABLE, 8'h00);
    pd_in <= 1'b1;
    repeat (10) @(posedge clk);
    chk("sleep", 16'h001F, slp);
    i_apoc_host.wr(OFS_PD_CONFIG, 8'h40);
    chk("sleep", 16'h0000, slp);
    pd_in <= 1'b0;
    i_apoc_host.wr(OFS_PD_CONFIG, 8'h00);
  endtask
  task automatic t_sync;
    i_apoc_host.wr(OFS_SYNC_ENABLE, 8'h80);
    repeat (2) begin
      i_apoc_host.wr(OFS_SYNC_PULSE, 8'h01);
      chk("sync", 16'h0001, {15'h0000, sync});
      i_apoc_host.wr(OFS_SYNC_PULSE, 8'h00);
      chk("sync", 16'h0000, {15'h0000, sync});
    end
    i_apoc_host.wr(OFS_SYNC_PULSE, 8'h41);
    chk("sync", 16'h0000, {15'h0000, sync});
    i_apoc_host.wr(OFS_SYNC_ENABLE, 8'h00);
    i_apoc_host.wr(OFS_SYNC_PULSE, 8'h01);
    chk("sync", 16'h0000, {15'h0000, sync});
  endtask
  task automatic t_ovr;
    int n;
    i_apoc_host.wr(OFS_FLAG_ROUTE, 8'h07);
    sample_a <= 16'h7FFE;
    sample_b <= 16'h0002;
    n = 0;
    while (!flag && n < 40) begin
      @(negedge clk);
      if (sample_strobe) n++;
    end
    chk("latency", 16'd18, n[15:0]);
    repeat (8) @(posedge clk);
    chk("word a", 16'h7FFF, enc_a);
    chk("word b", 16'h0003, enc_b);
    chk("pin", 16'h0001, {14'h0000, pd_oe_n, pd_out});
    chk("readback pin", 16'h0001, {14'h0000, rb_oe_n, rb});
    i_apoc_host.wr(OFS_TRIP_LEVEL, 8'hFF);
    repeat (100) @(posedge clk);
    chk("flag", 16'h0000, {15'h0000, flag});
    sample_a <= 16'h8000;
    repeat (100) @(posedge clk);
    chk("flag", 16'h0000, {15'h0000, flag});
    i_apoc_host.wr(OFS_TRIP_LEVEL, 8'hFE);
    repeat (100) @(posedge clk);
    chk("flag", 16'h0001, {15'h0000, flag});
    i_apoc_host.wr(OFS_FLAG_ROUTE, 8'h00);
    repeat (8) @(posedge clk);
    chk("word a", 16'h8000, enc_a);
    sample_a <= 16'h0000;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_sleep();
    t_sync();
    t_ovr();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
